// ---- ccr_chip_control.sv ----
`timescale 1ns/1ps
module ccr_chip_control
   import ccr_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      ce,
   input  wire logic                      vid_clk,
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   input  wire logic                      chip_reset_n,
   input  wire logic                      power_down_n,
   input  wire logic                      target_addr_strap,
   input  wire logic                      decoder_irq,
   input  wire logic [7:0]                sample_in,
   output logic                           pixclk_out,
   output ccr_pkg::ccr_byte_bus_type      pixel_byte_bus,
   output ccr_pkg::ccr_pins_type          timing_pins,
   output ccr_pkg::ccr_pad_cfg_type       pad_cfg,
   output logic                           power_down,
   output logic                           decoder_channel_enable
);
   import ccr_pkg::*;

   logic [1:0]    scl_sync, sda_sync, rstn_sync, pdn_sync, strap_sync, irq_sync;
   logic          scl_q, sda_q, rst_q, soft_rst, addr_sel;
   ccr_state_type state;
   logic [2:0]    bit_cnt;
   logic [7:0]    shreg, reg_index, rd_cur;
   logic          ack_on, is_read;
   logic [7:0]    reset_sleep_control, analog_macro_control;
   logic [7:0]    pixel_clock_config_a, pixel_clock_config_b;
   logic [7:0]    byte_port_config_a, byte_port_config_b, byte_port_config_c;
   logic [7:0]    pin_oe_reg, pin_out_reg, page_select_register;
   logic [7:0]    bank_mem [NUM_BANKS][128];
   logic          rst_all, scl_rise, scl_fall, i2c_start, i2c_stop;
   logic          wr_en;
   logic [7:0]    rx_byte;
   logic [6:0]    target_addr;

   function automatic logic bank_ok(input logic [7:0] page);
      bank_ok = (page < 8'(NUM_BANKS));
   endfunction : bank_ok

   // Pins come from outside this clock: two flops before any use
   always_ff @(posedge clk)
   begin
      scl_sync   <= {scl_sync[0], scl_in};
      sda_sync   <= {sda_sync[0], sda_in};
      rstn_sync  <= {rstn_sync[0], chip_reset_n};
      pdn_sync   <= {pdn_sync[0], power_down_n};
      strap_sync <= {strap_sync[0], target_addr_strap};
      irq_sync   <= {irq_sync[0], decoder_irq};
   end

   assign rst_all     = sys_rst | ~rstn_sync[1] | soft_rst;
   assign scl_rise    = scl_sync[1] & ~scl_q;
   assign scl_fall    = ~scl_sync[1] & scl_q;
   assign i2c_start   = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
   assign i2c_stop    = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
   assign rx_byte     = {shreg[6:0], sda_sync[1]};
   assign target_addr = addr_sel ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;
   assign wr_en       = ce & scl_rise & (state == ST_WDATA) & (bit_cnt == 3'd7);

   // Strap caught on the first cycle after reset releases
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rst_q    <= 1'b1;
         addr_sel <= 1'b0;
      end
      else if (ce)
      begin
         rst_q <= rst_all;
         if (rst_q && !rst_all)
            addr_sel <= strap_sync[1];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (ce)
      begin
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   // Read data decode: chip space ignores the page
   always_comb
   begin
      rd_cur = 8'h00;
      if (reg_index[7])
      begin
         unique case (reg_index)
            OFS_RST_SLEEP: rd_cur = reset_sleep_control;
            OFS_ANALOG:    rd_cur = analog_macro_control;
            OFS_PCLK_A:    rd_cur = pixel_clock_config_a;
            OFS_PCLK_B:    rd_cur = pixel_clock_config_b;
            OFS_PORT_A:    rd_cur = byte_port_config_a;
            OFS_PORT_B:    rd_cur = byte_port_config_b;
            OFS_PORT_C:    rd_cur = byte_port_config_c;
            OFS_PIN_OE:    rd_cur = pin_oe_reg;
            OFS_PIN_OUT:   rd_cur = pin_out_reg;
            OFS_PAGE:      rd_cur = page_select_register;
            default:       rd_cur = 8'h00;
         endcase
      end
      else if (bank_ok(page_select_register))
         rd_cur = bank_mem[page_select_register[1:0]][reg_index[6:0]];
   end

   // Target protocol engine
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         state     <= ST_IDLE;
         bit_cnt   <= 3'd0;
         shreg     <= 8'h00;
         reg_index <= 8'h00;
         ack_on    <= 1'b0;
         is_read   <= 1'b0;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
      end
      else if (ce)
      begin
         if (i2c_start)
         begin
            state   <= ST_ADDR;
            bit_cnt <= 3'd0;
            ack_on  <= 1'b0;
            sda_oe  <= 1'b0;
         end
         else if (i2c_stop)
         begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end
         else
         begin
            unique case (state)
               ST_IDLE: ;
               ST_ADDR, ST_INDEX, ST_WDATA:
                  if (scl_rise)
                  begin
                     shreg   <= rx_byte;
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd7)
                     begin
                        if (state == ST_ADDR)
                        begin
                           is_read <= rx_byte[0];
                           state   <= (rx_byte[7:1] == target_addr) ? ST_AACK : ST_IDLE;
                        end
                        else if (state == ST_INDEX)
                        begin
                           reg_index <= rx_byte;
                           state     <= ST_WACK;
                        end
                        else
                        begin
                           reg_index <= reg_index + 8'd1;
                           state     <= ST_WACK;
                        end
                     end
                  end
               ST_AACK, ST_WACK:
                  if (scl_fall)
                  begin
                     ack_on <= ~ack_on;
                     sda_oe <= ~ack_on;
                     if (ack_on)
                     begin
                        bit_cnt <= 3'd0;
                        if (state == ST_WACK)
                           state <= ST_WDATA;
                        else if (is_read)
                        begin
                           shreg  <= rd_cur;
                           sda_oe <= ~rd_cur[7];
                           state  <= ST_RDATA;
                        end
                        else
                           state <= ST_INDEX;
                     end
                  end
               ST_RDATA:
                  if (scl_fall)
                  begin
                     bit_cnt <= bit_cnt + 3'd1;
                     shreg   <= {shreg[6:0], 1'b0};
                     sda_oe  <= (bit_cnt == 3'd7) ? 1'b0 : ~shreg[6];
                     if (bit_cnt == 3'd7)
                        state <= ST_RACK;
                  end
               ST_RACK:
                  if (scl_rise)
                  begin
                     if (!sda_sync[1])
                     begin
                        reg_index <= reg_index + 8'd1;
                        state     <= ST_RLOAD;
                     end
                     else
                        state <= ST_IDLE;
                  end
               ST_RLOAD:
                  if (scl_fall)
                  begin
                     shreg   <= rd_cur;
                     sda_oe  <= ~rd_cur[7];
                     bit_cnt <= 3'd0;
                     state   <= ST_RDATA;
                  end
            endcase
         end
      end
   end

   // Chip space registers; software reset reloads all of them
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         reset_sleep_control  <= RST_RST_SLEEP;
         analog_macro_control <= RST_ANALOG;
         pixel_clock_config_a <= RST_PCLK_A;
         pixel_clock_config_b <= RST_PCLK_B;
         byte_port_config_a   <= RST_PORT_A;
         byte_port_config_b   <= RST_PORT_B;
         byte_port_config_c   <= RST_PORT_C;
         pin_oe_reg           <= RST_PIN;
         pin_out_reg          <= RST_PIN;
         page_select_register <= RST_PAGE;
         soft_rst             <= 1'b0;
      end
      else if (ce && wr_en && reg_index[7])
      begin
         unique case (reg_index)
            OFS_RST_SLEEP:
            begin
               reset_sleep_control <= rx_byte;
               soft_rst            <= rx_byte[SW_RESET_BIT];
            end
            OFS_ANALOG:  analog_macro_control <= rx_byte;
            OFS_PCLK_A:  pixel_clock_config_a <= rx_byte;
            OFS_PCLK_B:  pixel_clock_config_b <= rx_byte;
            OFS_PORT_A:  byte_port_config_a   <= rx_byte;
            OFS_PORT_B:  byte_port_config_b   <= rx_byte;
            OFS_PORT_C:  byte_port_config_c   <= rx_byte;
            OFS_PIN_OE:  pin_oe_reg           <= rx_byte;
            OFS_PIN_OUT: pin_out_reg          <= rx_byte;
            OFS_PAGE:    page_select_register <= rx_byte;
            default: ;
         endcase
      end
   end

   // Banked space: whole array resets; bad pages drop the write
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         for (int b = 0; b < NUM_BANKS; b++)
            for (int i = 0; i < 128; i++)
               bank_mem[b][i] <= 8'h00;
      end
      else if (ce && wr_en && !reg_index[7] && bank_ok(page_select_register))
         bank_mem[page_select_register[1:0]][reg_index[6:0]] <= rx_byte;
   end

   // Pad controls and status outputs, all registered
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         pad_cfg                <= '0;
         power_down             <= 1'b0;
         decoder_channel_enable <= 1'b0;
         timing_pins            <= '0;
      end
      else if (ce)
      begin
         pad_cfg.pixclk_delay_sel     <= pixel_clock_config_a[5:2];
         pad_cfg.pixclk_drive_sel     <= pixel_clock_config_a[7:6];
         pad_cfg.pixclk_freq_sel      <= pixel_clock_config_b[2:0];
         pad_cfg.pixclk_base_sel      <= pixel_clock_config_b[3];
         pad_cfg.pixclk_phase_sel     <= pixel_clock_config_b[6:4];
         pad_cfg.byte_port_drive_sel  <= byte_port_config_a[5:4];
         pad_cfg.byte_port_device_sel <= byte_port_config_a[7:6];
         pad_cfg.byte_port_delay      <= byte_port_config_c[3:0];
         pad_cfg.byte_port_phase_sel  <= (byte_port_config_b[MODE_LSB+:2] == 2'd0)
                                         ? byte_port_config_c[6:4] : 3'd0;
         power_down <= ~pdn_sync[1] | reset_sleep_control[SW_PD_BIT];
         decoder_channel_enable <= analog_macro_control[CH_EN_BIT];
         timing_pins.oe  <= pin_oe_reg[NUM_TIMING_PINS-1:0];
         timing_pins.out <= pin_out_reg[NUM_TIMING_PINS-1:0];
         if (pin_oe_reg[IRQ_ROUTE_BIT])
            timing_pins.out[VERTICAL_BLANK_PIN] <= irq_sync[1];
      end
   end

   // Video domain; config is quasi-static, so bitwise two-flop sync
   // is accepted here, with at most one byte of tear on a live change
   logic [1:0] v_rst_s, v_ce_s, v_en_s, v_clk_en_s, v_inv_s, v_chan_s;
   logic [1:0] v_mode0_s, v_mode1_s, v_str0_s, v_str1_s;
   logic       pix_phase;
   logic [10:0] hcnt;
   logic [9:0]  vcnt;
   logic        fld, vbl, hbl, hcode;
   logic [7:0]  next_word;

   always_ff @(posedge vid_clk)
   begin
      v_rst_s    <= {v_rst_s[0], rst_all};
      v_ce_s     <= {v_ce_s[0], ce};
      v_en_s     <= {v_en_s[0], byte_port_config_a[PORT_EN_BIT] & ~power_down};
      v_clk_en_s <= {v_clk_en_s[0], pixel_clock_config_a[CLK_EN_BIT]};
      v_inv_s    <= {v_inv_s[0], pixel_clock_config_a[CLK_INV_BIT]};
      v_chan_s   <= {v_chan_s[0], analog_macro_control[CH_EN_BIT]};
      v_mode0_s  <= {v_mode0_s[0], byte_port_config_b[MODE_LSB]};
      v_mode1_s  <= {v_mode1_s[0], byte_port_config_b[MODE_LSB+1]};
      v_str0_s   <= {v_str0_s[0], byte_port_config_b[STREAM_LSB]};
      v_str1_s   <= {v_str1_s[0], byte_port_config_b[STREAM_LSB+1]};
   end

   assign fld = (vcnt >= F2_LINE);
   assign vbl = (vcnt < VBLK1_END) || (fld && vcnt < VBLK2_END);
   assign hbl = (hcnt < SAV_POS + 11'd4);
   // Code H bit: the end code sits before the start code, so only it is high
   assign hcode = (hcnt < SAV_POS);

   // Next byte on the bus for the current raster position
   always_comb
   begin
      next_word = hcnt[0] ? BLANK_Y : BLANK_C;
      if (hcnt == 11'd0 || hcnt == SAV_POS)
         next_word = TRS_PRE;
      else if (hcnt < 11'd3 || (hcnt > SAV_POS && hcnt < SAV_POS + 11'd3))
         next_word = TRS_ZERO;
      else if (hcnt == 11'd3 || hcnt == SAV_POS + 11'd3)
         next_word = {1'b1, fld, vbl, hcode, vbl ^ hcode, fld ^ hcode,
                      fld ^ vbl, fld ^ vbl ^ hcode};
      else if (hcnt == 11'd4 && {v_mode1_s[1], v_mode0_s[1]} == 2'd1)
         next_word = {2'b01, v_str1_s[1], v_str0_s[1], v_chan_s[1], 3'b000};
      else if (!hbl && !vbl)
         next_word = (sample_in == TRS_PRE) ? 8'hfe :
                     (sample_in == TRS_ZERO) ? 8'h01 : sample_in;
   end

   // Pixel clock is vid_clk halved; one byte per pixel clock period
   always_ff @(posedge vid_clk)
   begin
      if (v_rst_s[1])
      begin
         pix_phase      <= 1'b0;
         pixclk_out     <= 1'b0;
         hcnt           <= 11'd0;
         vcnt           <= 10'd0;
         pixel_byte_bus <= '0;
      end
      else if (v_ce_s[1])
      begin
         pix_phase  <= ~pix_phase;
         pixclk_out <= v_clk_en_s[1] & (~pix_phase ^ v_inv_s[1]);
         if (pix_phase)
         begin
            hcnt <= (hcnt == H_TOTAL - 11'd1) ? 11'd0 : hcnt + 11'd1;
            if (hcnt == H_TOTAL - 11'd1)
               vcnt <= (vcnt == V_TOTAL - 10'd1) ? 10'd0 : vcnt + 10'd1;
            pixel_byte_bus.data <= next_word;
            pixel_byte_bus.oe   <= v_en_s[1];
         end
      end
   end

   // Checks in the control domain
   logic hdr_wr_q;
   always_ff @(posedge clk)
      hdr_wr_q <= wr_en && reg_index == OFS_RST_SLEEP && rx_byte[SW_RESET_BIT];

   strap_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && rst_q && !rst_all |=> addr_sel == $past(strap_sync[1]))
      else $error("strap not captured at reset release");
   addr_mismatch_a: assert property (@(posedge clk) disable iff (rst_all)
      ce && !i2c_start && !i2c_stop && state == ST_ADDR && scl_rise && bit_cnt == 3'd7
      && rx_byte[7:1] != target_addr |=> state == ST_IDLE)
      else $error("foreign address not ignored");
   index_step_a: assert property (@(posedge clk) disable iff (rst_all)
      wr_en && !i2c_start && !i2c_stop |=> reg_index == $past(reg_index) + 8'd1)
      else $error("index did not step after data byte");
   bad_page_a: assert property (@(posedge clk) disable iff (rst_all)
      !reg_index[7] && page_select_register >= 8'd3 |-> rd_cur == 8'h00)
      else $error("undefined page reads non-zero");
   chip_space_a: assert property (@(posedge clk) disable iff (rst_all)
      reg_index == OFS_ANALOG |-> rd_cur == analog_macro_control)
      else $error("chip space read depends on page");
   soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
      hdr_wr_q && ce |=> reset_sleep_control == RST_RST_SLEEP
      && byte_port_config_b == RST_PORT_B)
      else $error("software reset did not reload registers");
   power_down_a: assert property (@(posedge clk) disable iff (rst_all)
      ce && !pdn_sync[1] ##1 ce |-> power_down)
      else $error("power-down pin not honoured");

   // Checks in the video domain
   bus_float_a: assert property (@(posedge vid_clk) disable iff (v_rst_s[1])
      !v_en_s[1] && pix_phase && v_ce_s[1] |=> !pixel_byte_bus.oe)
      else $error("byte bus driven while port disabled");
   trs_preamble_a: assert property (@(posedge vid_clk) disable iff (v_rst_s[1])
      pix_phase && v_ce_s[1] && hcnt == SAV_POS |=> pixel_byte_bus.data == TRS_PRE
      ##2 pixel_byte_bus.data == TRS_ZERO ##2 pixel_byte_bus.data == TRS_ZERO)
      else $error("timing code preamble wrong");

   write_seen_c: cover property (@(posedge clk) wr_en);
   read_seen_c:  cover property (@(posedge clk) state == ST_RACK && scl_rise);
   eav_seen_c:   cover property (@(posedge vid_clk) pixel_byte_bus.oe && hcnt == 11'd4);
endmodule : ccr_chip_control

// ---- ccr_pkg.sv ----
package ccr_pkg;
   // Chip-level register offsets
   localparam logic [7:0] OFS_RST_SLEEP = 8'h80;
   localparam logic [7:0] OFS_ANALOG    = 8'h81;
   localparam logic [7:0] OFS_PCLK_A    = 8'h88;
   localparam logic [7:0] OFS_PCLK_B    = 8'h89;
   localparam logic [7:0] OFS_PORT_A    = 8'h8d;
   localparam logic [7:0] OFS_PORT_B    = 8'h8e;
   localparam logic [7:0] OFS_PORT_C    = 8'h8f;
   localparam logic [7:0] OFS_PIN_OE    = 8'h90;
   localparam logic [7:0] OFS_PIN_OUT   = 8'h91;
   localparam logic [7:0] OFS_PAGE      = 8'hff;
   // Reset values
   localparam logic [7:0] RST_RST_SLEEP = 8'h30;
   localparam logic [7:0] RST_ANALOG    = 8'h01;
   localparam logic [7:0] RST_PCLK_A    = 8'h01;
   localparam logic [7:0] RST_PCLK_B    = 8'h00;
   localparam logic [7:0] RST_PORT_A    = 8'h00;
   localparam logic [7:0] RST_PORT_B    = 8'h04;
   localparam logic [7:0] RST_PORT_C    = 8'h00;
   localparam logic [7:0] RST_PIN       = 8'h00;
   localparam logic [7:0] RST_PAGE      = 8'h00;
   // Field positions
   localparam int SW_RESET_BIT  = 0;
   localparam int SW_PD_BIT     = 2;
   localparam int CH_EN_BIT     = 0;
   localparam int CLK_EN_BIT    = 1 - 1;
   localparam int CLK_INV_BIT   = 1;
   localparam int PORT_EN_BIT   = 0;
   localparam int MODE_LSB      = 0;
   localparam int STREAM_LSB    = 2;
   localparam int IRQ_ROUTE_BIT = 7;
   // Target addresses and banking
   localparam logic [6:0] TARGET_ADDR_LOW  = 7'h2c;
   localparam logic [6:0] TARGET_ADDR_HIGH = 7'h2d;
   localparam int         NUM_BANKS        = 3;
   // Timing pin slots
   localparam int ACTIVE_VIDEO_PIN   = 0;
   localparam int VERTICAL_BLANK_PIN = 1;
   localparam int FIELD_ID_PIN       = 2;
   localparam int NUM_TIMING_PINS    = 5;
   // Embedded-sync raster, counted in pixel clock periods and lines
   localparam logic [10:0] H_TOTAL    = 11'd1716;
   localparam logic [10:0] SAV_POS    = 11'd272;
   localparam logic [9:0]  V_TOTAL    = 10'd525;
   localparam logic [9:0]  F2_LINE    = 10'd263;
   localparam logic [9:0]  VBLK1_END  = 10'd20;
   localparam logic [9:0]  VBLK2_END  = 10'd283;
   localparam logic [7:0]  TRS_PRE    = 8'hff;
   localparam logic [7:0]  TRS_ZERO   = 8'h00;
   localparam logic [7:0]  BLANK_Y    = 8'h10;
   localparam logic [7:0]  BLANK_C    = 8'h80;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_AACK  = 9'h004,
      ST_INDEX = 9'h008,
      ST_WDATA = 9'h010,
      ST_WACK  = 9'h020,
      ST_RDATA = 9'h040,
      ST_RACK  = 9'h080,
      ST_RLOAD = 9'h100
   } ccr_state_type;

   typedef struct packed {
      logic [7:0] data;
      logic       oe;
   } ccr_byte_bus_type;

   typedef struct packed {
      logic [NUM_TIMING_PINS-1:0] out;
      logic [NUM_TIMING_PINS-1:0] oe;
   } ccr_pins_type;

   typedef struct packed {
      logic [3:0] pixclk_delay_sel;
      logic [1:0] pixclk_drive_sel;
      logic [2:0] pixclk_freq_sel;
      logic       pixclk_base_sel;
      logic [2:0] pixclk_phase_sel;
      logic [1:0] byte_port_drive_sel;
      logic [1:0] byte_port_device_sel;
      logic [3:0] byte_port_delay;
      logic [2:0] byte_port_phase_sel;
   } ccr_pad_cfg_type;
endpackage : ccr_pkg

// ---- ccr_host_model.sv ----
`timescale 1ns/1ps
module ccr_host_model
   import ccr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sda_oe,
   output logic            scl,
   output logic            sda,
   output logic [7:0]      rd_byte,
   output logic            rd_valid,
   output logic            acked
);
   logic       drv = 1'b1;
   logic [6:0] dev = TARGET_ADDR_LOW;
   logic [7:0] r;
   logic       a;
   // Pull-up line: released means high
   assign sda = drv & ~sda_oe;
   initial
   begin
      scl = 1'b1;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
      acked = 1'b0;
   end
   // Slow quarter bit hides the target's sync latency
   task automatic q();
      repeat (10) @(posedge clk);
   endtask : q
   task automatic bit_io(input logic b, output logic s);
      drv <= b;
      q();
      scl <= 1'b1;
      q();
      s = sda;
      q();
      scl <= 1'b0;
      q();
   endtask : bit_io
   task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] o);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], o[i]);
      bit_io(ab, a);
   endtask : byte_io
   task automatic start(input logic rw);
      drv <= 1'b1;
      scl <= 1'b1;
      q();
      drv <= 1'b0;
      q();
      scl <= 1'b0;
      byte_io({dev, rw}, 1'b1, r);
      acked = ~a;
   endtask : start
   task automatic stop();
      drv <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      drv <= 1'b1;
      q();
   endtask : stop
   task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
      start(1'b0);
      byte_io(idx, 1'b1, r);
      foreach (d[i])
         byte_io(d[i], 1'b1, r);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input int n);
      start(1'b0);
      byte_io(idx, 1'b1, r);
      start(1'b1);
      for (int i = 0; i < n; i++)
      begin
         byte_io(8'hff, i == n - 1, r);
         rd_byte <= r;
         rd_valid <= 1'b1;
         @(posedge clk);
         rd_valid <= 1'b0;
      end
      stop();
   endtask : rd
endmodule : ccr_host_model

// ---- chip_control_i2c_regs_tb.sv ----
`timescale 1ns/1ps
module chip_control_i2c_regs_tb;
   import ccr_pkg::*;
   logic clk = 1'b0, vid_clk = 1'b0, sys_rst = 1'b1, rst_n = 1'b1, pd_n = 1'b1, irq = 1'b0;
   logic [7:0] samp = 8'h00, rd_byte, r0, r1, exp_q[$];
   logic scl, sda, sda_oe, pixclk, pd, ch_en, rd_valid, acked, strap = 1'b0;
   logic [31:0] vh;
   ccr_byte_bus_type bus;
   ccr_pins_type     pins;
   ccr_pad_cfg_type  pad;
   int n_errors = 0, n_tests = 0, cyc = 0, n_codes = 0;
   always #4 clk = ~clk;
   initial #1.3 forever #3 vid_clk = ~vid_clk;
   always @(posedge vid_clk) {irq, samp} <= 9'($urandom);
   ccr_chip_control ccr_chip_control_inst (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
      .vid_clk(vid_clk), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .chip_reset_n(rst_n), .power_down_n(pd_n), .target_addr_strap(strap),
      .decoder_irq(irq), .sample_in(samp), .pixclk_out(pixclk), .pixel_byte_bus(bus),
      .timing_pins(pins), .pad_cfg(pad), .power_down(pd), .decoder_channel_enable(ch_en));
   ccr_host_model ccr_host_model_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
      .rd_byte(rd_byte), .rd_valid(rd_valid), .acked(acked));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("errors %0d of %0d checks", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
      foreach (e[i])
         exp_q.push_back(e[i]);
      ccr_host_model_inst.rd(idx, e.size());
   endtask : rd
   task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
      ccr_host_model_inst.wr(idx, d);
      repeat (8) @(posedge clk);
   endtask : wr
   always @(posedge clk)
      if (rd_valid === 1'b1 && exp_q.size() > 0)
         check(rd_byte, exp_q.pop_front());
   // First four codes fall in blanked lines of field one, before any reset
   always @(posedge pixclk)
   begin
      vh = {vh[23:0], bus.data};
      if (vh[31:8] === 24'hff0000 && n_codes < 4)
      begin
         check(vh[7:0], n_codes[0] ? 8'hab : 8'hb6);
         n_codes++;
      end
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   initial
   begin
      void'($urandom(32'he81e6577));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge clk);
      rd(OFS_RST_SLEEP, '{8'h30, 8'h01});
      rd(OFS_PCLK_A, '{8'h01, 8'h00});
      rd(OFS_PORT_A, '{8'h00, 8'h04, 8'h00});
      rd(OFS_PAGE, '{8'h00});
      check({7'h0, ch_en}, 8'h01);
      check({7'h0, bus.oe}, 8'h00);
      check({3'h0, pins.oe}, 8'h00);
      r0 = 8'($urandom);
      r1 = 8'($urandom) & 8'h7f;
      wr(OFS_PCLK_A, '{r0, r1});
      check({7'h0, acked}, 8'h01);
      rd(OFS_PCLK_A, '{r0, r1});
      check({4'h0, pad.pixclk_delay_sel}, {4'h0, r0[5:2]});
      check({5'h0, pad.pixclk_freq_sel}, {5'h0, r1[2:0]});
      for (int p = 0; p < 4; p++)
      begin
         wr(OFS_PAGE, '{8'(p)});
         wr(8'h10, '{8'(8'ha0 + p)});
      end
      for (int p = 0; p < 4; p++)
      begin
         wr(OFS_PAGE, '{8'(p)});
         rd(8'h10, '{(p < 3) ? 8'(8'ha0 + p) : 8'h00});
      end
      rd(OFS_ANALOG, '{8'h01});
      wr(OFS_PAGE, '{8'h00});
      ccr_host_model_inst.dev = TARGET_ADDR_HIGH;
      wr(OFS_PORT_C, '{8'h55});
      check({7'h0, acked}, 8'h00);
      ccr_host_model_inst.dev = TARGET_ADDR_LOW;
      rd(OFS_PORT_C, '{8'h00});
      wr(OFS_PORT_A, '{8'h01});
      check({7'h0, bus.oe}, 8'h01);
      wr(OFS_PIN_OE, '{8'h1f, 8'h15});
      check({3'h0, pins.oe}, 8'h1f);
      check({3'h0, pins.out}, 8'h15);
      pd_n <= 1'b0;
      repeat (8) @(posedge clk);
      check({6'h0, pd, bus.oe}, 8'h02);
      pd_n <= 1'b1;
      wr(OFS_RST_SLEEP, '{8'h34});
      check({7'h0, pd}, 8'h01);
      wr(OFS_PORT_B, '{8'h07});
      wr(OFS_RST_SLEEP, '{8'h31});
      repeat (40) @(posedge clk);
      rd(OFS_PORT_B, '{8'h04});
      wr(OFS_PCLK_B, '{8'h05});
      strap <= 1'b1;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      ccr_host_model_inst.dev = TARGET_ADDR_HIGH;
      rd(OFS_PCLK_B, '{8'h00});
      check({7'h0, acked}, 8'h01);
      check(8'(n_codes), 8'h04);
      give_verdict();
   end
endmodule : chip_control_i2c_regs_tb
